// File: logic/psc_cfg.svh
/*
  Constants for the pluggable module sideband control: bus address,
  memory map offsets and fields, reset values and timing counts.
  Assumes a single 50 MHz clock on both ends of the link.
*/
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

// Serial bus address of the module
`define PSC_DEV_ADDR         7'h50
// Memory map offsets
`define PSC_REG_STATUS       8'h00
`define PSC_REG_FLAGS        8'h01
`define PSC_REG_LANE_OFF     8'h02
// Status fields
`define PSC_ST_NOT_READY_BIT 0
`define PSC_ST_LOW_POWER_BIT 1
// Flag fields: bit 0 reset done, lane faults above it
`define PSC_FLG_RST_DONE_BIT 0
// Reset values
`define PSC_LANE_OFF_RST     4'h0
// Timing counts
`define PSC_RST_MIN_CYC      8
`define PSC_INIT_CYC         16
`define PSC_CLK_PERIOD_NS    20
`define PSC_SCL_PERIOD_NS    10000
`define PSC_TICK_CYC         (`PSC_SCL_PERIOD_NS / (3 * `PSC_CLK_PERIOD_NS))
`endif

// File: logic/psc_host_end.sv
/*
  Host end of the sideband link: drives select, reset and low-power
  pins, and runs single byte read and write transfers on the bus.
  Assumes one module behind this port and no clock stretching.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psc_cfg.svh"
module psc_host_end #(
  parameter logic [6:0] DEV_ADDR = `PSC_DEV_ADDR,
  parameter int         TICK_CYC = `PSC_TICK_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Sideband pins
  psc_link_if.host_end    link,
  // Pin requests
  input  wire logic       select_req,
  input  wire logic       reset_req,
  input  wire logic       low_power_req,
  // Command
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_ptr,
  input  wire logic [7:0] cmd_wdata,
  // Response
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            rsp_nack,
  // Module status
  output logic            module_present,
  output logic            module_interrupt
);

  ////////////////////////////////////////////////////////////////////
  // Pins and synchronisers

  logic [2:0]              s1_q;
  logic [2:0]              s2_q;
  logic [2:0]              s3_q;
  logic [2:0]              f_q;
  logic                    sel_q;
  logic                    rst_q;
  logic                    lpm_q;

  // Level pins registered from the user side
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sel_q <= 1'b0;
      rst_q <= 1'b0;
      lpm_q <= 1'b1;
    end else begin
      sel_q <= select_req;
      rst_q <= reset_req;
      lpm_q <= low_power_req;
    end
  end

  assign link.module_select_n  = ~sel_q;
  assign link.module_reset_n   = ~rst_q;
  assign link.low_power_select = lpm_q;

  // Three stages, a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      s3_q <= 3'h7;
      f_q  <= 3'h7;
    end else begin
      s1_q <= {link.sda_i, link.interrupt_out_n, link.module_present_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  assign module_present   = ~f_q[0];
  assign module_interrupt = ~f_q[1];

  ////////////////////////////////////////////////////////////////////
  // Bus master

  psc_pkg::psc_host_state_t st_q;
  logic [15:0]             tk_q;
  logic                    tick;
  logic [2:0]              seq_q;
  logic [1:0]              ph_q;
  logic [3:0]              bi_q;
  logic [7:0]              sh_q;
  logic                    rd_q;
  logic [7:0]              ptr_q;
  logic [7:0]              wd_q;
  logic                    scl_oe_q;
  logic                    sda_oe_q;
  logic [2:0]              seq_n;
  psc_pkg::psc_host_state_t sym_n;
  logic [7:0]              txb_n;

  assign cmd_ready = (st_q == psc_pkg::H_IDLE);
  assign tick      = (tk_q == 16'(TICK_CYC - 1));
  assign seq_n     = seq_q + 3'h1;

  // Next symbol: write S,A,P,D,stop; read S,A,P,S,A,R,stop
  always_comb begin
    sym_n = psc_pkg::H_TX;
    txb_n = ptr_q;
    case (seq_n)
      3'h1: txb_n = {DEV_ADDR, 1'b0};
      3'h2: txb_n = ptr_q;
      3'h3: begin
        sym_n = rd_q ? psc_pkg::H_START : psc_pkg::H_TX;
        txb_n = wd_q;
      end
      3'h4: begin
        sym_n = rd_q ? psc_pkg::H_TX : psc_pkg::H_STOP;
        txb_n = {DEV_ADDR, 1'b1};
      end
      3'h5: sym_n = psc_pkg::H_RX;
      default: sym_n = psc_pkg::H_STOP;
    endcase
  end

  // Tick divider, three ticks per bus bit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tk_q <= 16'h0000;
    end else if (st_q == psc_pkg::H_IDLE || tick) begin
      tk_q <= 16'h0000;
    end else begin
      tk_q <= tk_q + 16'h0001;
    end
  end

  // Symbol sequencer and bit engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= psc_pkg::H_IDLE;
      seq_q     <= 3'h0;
      ph_q      <= 2'h0;
      bi_q      <= 4'h0;
      sh_q      <= 8'h00;
      rd_q      <= 1'b0;
      ptr_q     <= 8'h00;
      wd_q      <= 8'h00;
      scl_oe_q  <= 1'b0;
      sda_oe_q  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      rsp_nack  <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_q)
        psc_pkg::H_IDLE: begin
          if (cmd_valid) begin
            st_q     <= psc_pkg::H_START;
            seq_q    <= 3'h0;
            ph_q     <= 2'h0;
            rd_q     <= cmd_read;
            ptr_q    <= cmd_ptr;
            wd_q     <= cmd_wdata;
            rsp_nack <= 1'b0;
          end
        end
        psc_pkg::H_START: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            case (ph_q)
              2'h0: begin
                sda_oe_q <= 1'b0;
                scl_oe_q <= 1'b1;
              end
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1;
              default: begin
                scl_oe_q <= 1'b1;
                seq_q    <= seq_n;
                st_q     <= sym_n;
                sh_q     <= txb_n;
                bi_q     <= 4'h0;
              end
            endcase
          end
        end
        psc_pkg::H_TX, psc_pkg::H_RX: begin
          if (tick) begin
            ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              scl_oe_q <= 1'b1;
              sda_oe_q <= (st_q == psc_pkg::H_TX) && (bi_q != 4'h8) && !sh_q[7];
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else begin
              bi_q <= bi_q + 4'h1;
              if (bi_q != 4'h8) begin
                sh_q <= {sh_q[6:0], f_q[2]};
              end else if (st_q == psc_pkg::H_TX && f_q[2]) begin
                rsp_nack <= 1'b1;
                st_q     <= psc_pkg::H_STOP;
              end else begin
                seq_q <= seq_n;
                st_q  <= sym_n;
                sh_q  <= (st_q == psc_pkg::H_RX) ? sh_q : txb_n;
                bi_q  <= 4'h0;
              end
            end
          end
        end
        psc_pkg::H_STOP: begin
          if (tick) begin
            ph_q <= ph_q + 2'h1;
            if (ph_q == 2'h0) begin
              scl_oe_q <= 1'b1;
              sda_oe_q <= 1'b1;
            end else if (ph_q == 2'h1) begin
              scl_oe_q <= 1'b0;
            end else begin
              sda_oe_q  <= 1'b0;
              rsp_valid <= 1'b1;
              rsp_rdata <= sh_q;
              st_q      <= psc_pkg::H_IDLE;
            end
          end
        end
        default: st_q <= psc_pkg::H_IDLE;
      endcase
    end
  end

  // Open drain bus pins only ever pull low
  assign link.host_scl_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = sda_oe_q;

endmodule // psc_host_end
`default_nettype wire

// File: logic/psc_link_if.sv
/*
  Sideband pins between host board and module, with open drain
  resolution of clock, data and interrupt through host pull-ups.
  Assumes each party drives only its own modport signals.
*/
`timescale 1ns/1ps
`default_nettype none
interface psc_link_if;
  logic module_select_n;
  logic module_reset_n;
  logic low_power_select;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic dev_int_o;
  logic dev_int_oe;
  logic module_present_n;
  logic scl_i;
  logic sda_i;
  logic interrupt_out_n;

  // Wired-AND lines, high through pull-ups when nobody drives low
  assign scl_i = ~(host_scl_oe & ~host_scl_o);
  assign sda_i = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  assign interrupt_out_n = ~(dev_int_oe & ~dev_int_o);

  modport module_end (
    input  module_select_n, module_reset_n, low_power_select, scl_i, sda_i,
    output dev_sda_o, dev_sda_oe, dev_int_o, dev_int_oe, module_present_n
  );
  modport host_end (
    output module_select_n, module_reset_n, low_power_select,
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input  sda_i, interrupt_out_n, module_present_n
  );
endinterface
`default_nettype wire

// File: logic/psc_module_end.sv
/*
  Module end of the sideband link: serial memory map slave, reset
  filter, completion and fault interrupt, presence and power control.
  Assumes the host makes the serial clock slow against clock and
  selects only this module while talking to it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "psc_cfg.svh"
module psc_module_end #(
  parameter logic [6:0] DEV_ADDR    = `PSC_DEV_ADDR,
  parameter int         RST_MIN_CYC = `PSC_RST_MIN_CYC,
  parameter int         INIT_CYC    = `PSC_INIT_CYC,
  parameter int         LANES       = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Sideband pins
  psc_link_if.module_end        link,
  // Lane side
  input  wire logic [LANES-1:0] lane_fault,
  output logic      [LANES-1:0] lane_shutdown,
  output logic                  high_power_en,
  output logic                  module_ready
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [4:0]              s1_q;
  logic [4:0]              s2_q;
  logic [4:0]              s3_q;
  logic [4:0]              f_q;
  logic                    scl_p_q;
  logic                    sda_p_q;
  logic                    scl;
  logic                    sda;
  logic                    sel_n;
  logic                    mrst_n;
  logic                    lpm;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    bus_start;
  logic                    bus_stop;

  // Three stages, a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= 5'h1F;
      s2_q <= 5'h1F;
      s3_q <= 5'h1F;
      f_q  <= 5'h1F;
    end else begin
      s1_q <= {link.scl_i, link.sda_i, link.module_select_n,
               link.module_reset_n, link.low_power_select};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
    end
  end

  assign scl    = f_q[4];
  assign sda    = f_q[3];
  assign sel_n  = f_q[2];
  assign mrst_n = f_q[1];
  assign lpm    = f_q[0];

  // Previous bus levels for edge and condition detection
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
    end
  end

  assign scl_rise  = scl & ~scl_p_q;
  assign scl_fall  = ~scl & scl_p_q;
  assign bus_start = scl & scl_p_q & sda_p_q & ~sda;
  assign bus_stop  = scl & scl_p_q & ~sda_p_q & sda;

  ////////////////////////////////////////////////////////////////////
  // Reset filter and completion

  logic [15:0]             rst_cnt_q;
  logic                    full_rst_q;
  logic [15:0]             init_cnt_q;
  logic                    not_ready_q;
  logic                    done_pulse;

  // Count low samples, full reset once the minimum length is passed
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_cnt_q  <= 16'h0000;
      full_rst_q <= 1'b0;
    end else if (mrst_n) begin
      rst_cnt_q  <= 16'h0000;
      full_rst_q <= 1'b0;
    end else if (rst_cnt_q < 16'(RST_MIN_CYC)) begin
      rst_cnt_q  <= rst_cnt_q + 16'h0001;
    end else begin
      full_rst_q <= 1'b1;
    end
  end

  assign done_pulse = not_ready_q & (init_cnt_q == 16'h0000);

  // Init delay after power-up or full reset, then not-ready clears
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_q  <= 16'(INIT_CYC);
      not_ready_q <= 1'b1;
    end else if (full_rst_q) begin
      init_cnt_q  <= 16'(INIT_CYC);
      not_ready_q <= 1'b1;
    end else if (done_pulse) begin
      not_ready_q <= 1'b0;
    end else if (not_ready_q) begin
      init_cnt_q  <= init_cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Serial memory map slave

  psc_pkg::psc_dev_state_t st_q;
  logic [7:0]              sh_q;
  logic [3:0]              cnt_q;
  logic [7:0]              ptr_q;
  logic                    first_q;
  logic                    rw_q;
  logic                    nack_q;
  logic                    sda_oe_q;
  logic [7:0]              rd_byte;
  logic                    rd_load;
  logic                    wr_en;
  logic [LANES:0]          flags_q;
  logic [LANES:0]          flags_clr;
  logic [LANES-1:0]        lane_off_q;

  // Read data for the current pointer, unmapped reads give zero
  always_comb begin
    rd_byte = 8'h00;
    case (ptr_q)
      `PSC_REG_STATUS: begin
        rd_byte[`PSC_ST_NOT_READY_BIT] = not_ready_q;
        rd_byte[`PSC_ST_LOW_POWER_BIT] = lpm;
      end
      `PSC_REG_FLAGS:    rd_byte[LANES:0]   = flags_q;
      `PSC_REG_LANE_OFF: rd_byte[LANES-1:0] = lane_off_q;
      default:           rd_byte            = 8'h00;
    endcase
  end

  assign rd_load = scl_fall & ~sel_n & ~full_rst_q & ~bus_start & ~bus_stop &
                   (((st_q == psc_pkg::D_ACKA) & rw_q) |
                    ((st_q == psc_pkg::D_RACK) & ~nack_q));
  assign wr_en   = scl_fall & ~sel_n & ~full_rst_q & (st_q == psc_pkg::D_WR) &
                   (cnt_q == 4'h8) & ~first_q;

  // Bus engine: pointer byte first, then data with auto increment
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= psc_pkg::D_IDLE;
      sh_q     <= 8'h00;
      cnt_q    <= 4'h0;
      ptr_q    <= 8'h00;
      first_q  <= 1'b0;
      rw_q     <= 1'b0;
      nack_q   <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (sel_n || full_rst_q) begin
      st_q     <= psc_pkg::D_IDLE;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      st_q     <= psc_pkg::D_ADDR;
      cnt_q    <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (bus_stop) begin
      st_q     <= psc_pkg::D_IDLE;
      sda_oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (st_q == psc_pkg::D_ADDR || st_q == psc_pkg::D_WR) begin
        sh_q  <= {sh_q[6:0], sda};
        cnt_q <= cnt_q + 4'h1;
      end
      if (st_q == psc_pkg::D_RACK) begin
        nack_q <= sda;
      end
    end else if (scl_fall) begin
      case (st_q)
        psc_pkg::D_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              sda_oe_q <= 1'b1;
              rw_q     <= sh_q[0];
              first_q  <= ~sh_q[0];
              st_q     <= psc_pkg::D_ACKA;
            end else begin
              st_q <= psc_pkg::D_IDLE;
            end
          end
        end
        psc_pkg::D_ACKA, psc_pkg::D_RACK: begin
          if (rd_load) begin
            sh_q     <= rd_byte;
            sda_oe_q <= ~rd_byte[7];
            ptr_q    <= ptr_q + 8'h01;
            cnt_q    <= 4'h0;
            st_q     <= psc_pkg::D_RD;
          end else if (st_q == psc_pkg::D_ACKA) begin
            sda_oe_q <= 1'b0;
            cnt_q    <= 4'h0;
            st_q     <= psc_pkg::D_WR;
          end else begin
            st_q <= psc_pkg::D_IDLE;
          end
        end
        psc_pkg::D_WR: begin
          if (cnt_q == 4'h8) begin
            sda_oe_q <= 1'b1;
            st_q     <= psc_pkg::D_ACKW;
            first_q  <= 1'b0;
            ptr_q    <= first_q ? sh_q : ptr_q + 8'h01;
          end
        end
        psc_pkg::D_ACKW: begin
          sda_oe_q <= 1'b0;
          cnt_q    <= 4'h0;
          st_q     <= psc_pkg::D_WR;
        end
        psc_pkg::D_RD: begin
          if (cnt_q == 4'h7) begin
            sda_oe_q <= 1'b0;
            st_q     <= psc_pkg::D_RACK;
          end else begin
            sh_q     <= {sh_q[6:0], 1'b0};
            sda_oe_q <= ~sh_q[6];
            cnt_q    <= cnt_q + 4'h1;
          end
        end
        default: st_q <= psc_pkg::D_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Settings, flags and outputs

  // Lane shutdown settings, defaults restored by full reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lane_off_q <= `PSC_LANE_OFF_RST;
    end else if (full_rst_q) begin
      lane_off_q <= `PSC_LANE_OFF_RST;
    end else if (wr_en && ptr_q == `PSC_REG_LANE_OFF) begin
      lane_off_q <= sh_q[LANES-1:0];
    end
  end

  // Reading the flag byte clears only the bits that were read
  assign flags_clr = (rd_load && ptr_q == `PSC_REG_FLAGS) ? flags_q : '0;

  // Sticky flags, a new event wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= '0;
    end else if (full_rst_q) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~flags_clr) | {lane_fault, done_pulse};
    end
  end

  // Power and lane controls, everything held off until ready
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lane_shutdown <= '1;
      high_power_en <= 1'b0;
      module_ready  <= 1'b0;
    end else begin
      lane_shutdown <= lane_off_q | {LANES{not_ready_q}};
      high_power_en <= ~lpm & ~not_ready_q;
      module_ready  <= ~not_ready_q;
    end
  end

  // Open drain pins only ever pull low
  assign link.dev_sda_o       = 1'b0;
  assign link.dev_sda_oe      = sda_oe_q;
  assign link.dev_int_o       = 1'b0;
  assign link.dev_int_oe      = |flags_q;
  assign link.module_present_n = 1'b0;

endmodule // psc_module_end
`default_nettype wire

// File: logic/psc_pkg.sv
/*
  Types shared by the two ends of the sideband link.
  Assumes psc_cfg.svh supplies the numeric constants.
*/
`default_nettype none
package psc_pkg;
  // Module end serial slave states
  typedef enum logic [6:0] {
    D_IDLE = 7'h01,
    D_ADDR = 7'h02,
    D_ACKA = 7'h04,
    D_WR   = 7'h08,
    D_ACKW = 7'h10,
    D_RD   = 7'h20,
    D_RACK = 7'h40
  } psc_dev_state_t;
  // Host end serial master states
  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_TX    = 5'h04,
    H_RX    = 5'h08,
    H_STOP  = 5'h10
  } psc_host_state_t;
endpackage
`default_nettype wire

// File: tb/psc_props.sv
/*
  Checker for the sideband link pins between the two ends.
  Assumes RST_MIN_CYC 8 and INIT_CYC 16 in the module end.
*/
`timescale 1ns/1ps
`default_nettype none
module psc_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Host driven pins
  input wire logic module_select_n,
  input wire logic module_reset_n,
  // Module driven pins
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic dev_int_o,
  input wire logic dev_int_oe,
  input wire logic module_present_n,
  input wire logic interrupt_out_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [5:0] low_q;
  ////////////////////////////////////////////////////////////
  // Count cycles of reset pin low, saturating
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) low_q <= 6'h00;
    else if (module_reset_n) low_q <= 6'h00;
    else if (low_q != 6'h3f) low_q <= low_q + 6'h01;
  end
  // Release after a long pulse, then completion posted
  sequence s_long_release;
    $rose(module_reset_n) && low_q >= 6'h0e;
  endsequence
  sequence s_posted;
    interrupt_out_n [*8] ##[2:24] !interrupt_out_n;
  endsequence
  ////////////////////////////////////////////////////////////
  a_present_low: assert property (module_present_n == 1'b0)
    else $error("presence pin not low");
  a_int_low_only: assert property (dev_int_oe |-> !dev_int_o)
    else $error("interrupt driven high");
  a_sda_low_only: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("data driven high");
  a_deselect_quiet: assert property (module_select_n [*6] |-> !dev_sda_oe)
    else $error("data driven while deselected");
  a_reset_quiet: assert property (low_q >= 6'h0e |-> !dev_int_oe && !dev_sda_oe)
    else $error("pins driven in full reset");
  a_done_posted: assert property (s_long_release |-> s_posted)
    else $error("no completion after reset pulse");
  a_powerup_posted: assert property ($rose(rst_b) |-> s_posted)
    else $error("no completion after power up");
  a_int_holds: assert property (!interrupt_out_n && module_select_n && module_reset_n
    |=> !interrupt_out_n)
    else $error("interrupt released without read");
endmodule // psc_props
`default_nettype wire

// File: tb/tb_pluggable_module_sideband_control.sv
/*
  Bench joining host end and module end through the link.
  Assumes a 50 MHz clock and TICK_CYC of 10 on the host end.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_pluggable_module_sideband_control;
  logic       clock = 1'b0;
  logic       rst_b = 1'b0;
  logic       select_req, reset_req, low_power_req, cmd_valid, cmd_read;
  logic       cmd_ready, rsp_valid, rsp_nack, module_present, module_interrupt;
  logic       high_power_en, module_ready;
  logic [7:0] cmd_ptr, cmd_wdata, rsp_rdata, rd;
  logic [3:0] lane_fault, lane_shutdown;
  int         err_total = 0;
  int         comparisons = 0;
  psc_link_if link ();
  psc_module_end i_psc_module_end (.clock(clock), .rst_b(rst_b), .link(link),
    .lane_fault(lane_fault), .lane_shutdown(lane_shutdown),
    .high_power_en(high_power_en), .module_ready(module_ready));
  psc_host_end #(.TICK_CYC(10)) i_psc_host_end (.clock(clock), .rst_b(rst_b),
    .link(link), .select_req(select_req), .reset_req(reset_req),
    .low_power_req(low_power_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_read(cmd_read), .cmd_ptr(cmd_ptr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack),
    .module_present(module_present), .module_interrupt(module_interrupt));
  psc_props i_psc_props (.clock(clock), .rst_b(rst_b),
    .module_select_n(link.module_select_n), .module_reset_n(link.module_reset_n),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe),
    .dev_int_o(link.dev_int_o), .dev_int_oe(link.dev_int_oe),
    .module_present_n(link.module_present_n), .interrupt_out_n(link.interrupt_out_n));
  ////////////////////////////////////////////////////////////
  // Free running clock
  always #10 clock = ~clock;
  // Byte compare
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Let cycles pass, then settle
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Pin requests at a rising edge
  task automatic pins(input logic s, input logic r, input logic l, input logic [3:0] f);
    @(posedge clock);
    select_req <= s;
    reset_req <= r;
    low_power_req <= l;
    lane_fault <= f;
  endtask
  // One command, wait for its response
  task automatic xfer(input logic rdn, input logic [7:0] ptr, input logic [7:0] wd);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_read <= rdn;
    cmd_ptr <= ptr;
    cmd_wdata <= wd;
    @(posedge clock);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clock);
      #1;
      if (rsp_valid === 1'b1) break;
    end
    if (rsp_valid !== 1'b1) begin
      err_total++;
      $display("[FAIL] response expected 1 seen 0");
    end
    rd = rsp_rdata;
  endtask
  // Read and compare
  task automatic rdchk(input string name, input logic [7:0] ptr, input logic [7:0] exp);
    xfer(1'b1, ptr, 8'h00);
    chk(name, exp, rd);
    chk({name, "_ack"}, 8'h00, {7'h00, rsp_nack});
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    {select_req, reset_req, low_power_req, lane_fault} = 7'h50;
    {cmd_valid, cmd_read, cmd_ptr, cmd_wdata} = 18'h0_0000;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    idle(40);
    chk("present", 8'h01, {7'h00, module_present});
    chk("int_up", 8'h01, {7'h00, module_interrupt});
    chk("low_pwr", 8'h00, {7'h00, high_power_en});
    chk("ready", 8'h01, {7'h00, module_ready});
    chk("cmd_idle", 8'h01, {7'h00, cmd_ready});
    rdchk("status", 8'h00, 8'h02);
    rdchk("flags", 8'h01, 8'h01);
    idle(8);
    chk("int_rel", 8'h00, {7'h00, module_interrupt});
    $display("test power_up done");
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 8'h02, 8'h01 << i);
      chk("lane_off", 8'h01 << i, {4'h0, lane_shutdown});
      rdchk("lane_rd", 8'h02, 8'h01 << i);
    end
    xfer(1'b0, 8'h00, 8'hff);
    rdchk("status_ro", 8'h00, 8'h02);
    $display("test lanes done");
    pins(1'b1, 1'b0, 1'b1, 4'h4);
    pins(1'b0, 1'b0, 1'b1, 4'h0);
    idle(8);
    chk("int_fault", 8'h01, {7'h00, module_interrupt});
    xfer(1'b0, 8'h02, 8'h0f);
    chk("nack", 8'h01, {7'h00, rsp_nack});
    chk("lane_keep", 8'h08, {4'h0, lane_shutdown});
    pins(1'b1, 1'b0, 1'b0, 4'h0);
    idle(8);
    rdchk("flags_f", 8'h01, 8'h08);
    idle(8);
    chk("int_rel2", 8'h00, {7'h00, module_interrupt});
    chk("high_pwr", 8'h01, {7'h00, high_power_en});
    rdchk("status_lp", 8'h00, 8'h00);
    $display("test fault_select done");
    pins(1'b1, 1'b1, 1'b0, 4'h0);
    repeat (3) @(posedge clock);
    pins(1'b1, 1'b0, 1'b0, 4'h0);
    idle(20);
    chk("short_rst", 8'h08, {4'h0, lane_shutdown});
    pins(1'b1, 1'b1, 1'b0, 4'h0);
    idle(30);
    chk("rst_lanes", 8'h0f, {4'h0, lane_shutdown});
    chk("rst_ready", 8'h00, {7'h00, module_ready});
    pins(1'b1, 1'b0, 1'b0, 4'h0);
    idle(40);
    chk("int_done", 8'h01, {7'h00, module_interrupt});
    chk("lanes_dflt", 8'h00, {4'h0, lane_shutdown});
    rdchk("lane_dflt", 8'h02, 8'h00);
    rdchk("status_rst", 8'h00, 8'h00);
    rdchk("flags_rst", 8'h01, 8'h01);
    $display("test reset done");
    tally_and_finish;
  end
  // Cut a hang short well past the expected run length
  initial begin
    repeat (60000) @(posedge clock);
    err_total++;
    tally_and_finish;
  end
endmodule // tb_pluggable_module_sideband_control
`default_nettype wire
